//--- sfr_pkg.sv
// Purpose: shared constants and types for the function register area and port block
// Assumes: offsets are register indices, byte address is four times the index
// Notes:   reset values with undefined bits are given as zero in those bits

package sfr_pkg;

   // ***************************************************************
   // register indices
   // ***************************************************************
   localparam int         REG_COUNT               = 19;
   localparam logic [7:0] IDX_STACK_POINTER       = 8'h81;
   localparam logic [7:0] IDX_DATA_POINTER_LOW    = 8'h82;
   localparam logic [7:0] IDX_DATA_POINTER_HIGH   = 8'h83;
   localparam logic [7:0] IDX_POWER_CONTROL       = 8'h87;
   localparam logic [7:0] IDX_TIMER_CONTROL       = 8'h88;
   localparam logic [7:0] IDX_TIMER_MODE_CFG      = 8'h89;
   localparam logic [7:0] IDX_TIMER0_COUNT_LOW    = 8'h8a;
   localparam logic [7:0] IDX_TIMER1_COUNT_LOW    = 8'h8b;
   localparam logic [7:0] IDX_TIMER0_COUNT_HIGH   = 8'h8c;
   localparam logic [7:0] IDX_TIMER1_COUNT_HIGH   = 8'h8d;
   localparam logic [7:0] IDX_PORT_ONE_LATCH      = 8'h90;
   localparam logic [7:0] IDX_SERIAL_CONTROL      = 8'h98;
   localparam logic [7:0] IDX_SERIAL_DATA_HOLDING = 8'h99;
   localparam logic [7:0] IDX_IRQ_MASK_REG        = 8'ha8;
   localparam logic [7:0] IDX_PORT_THREE_LATCH    = 8'hb0;
   localparam logic [7:0] IDX_IRQ_PRIORITY        = 8'hb8;
   localparam logic [7:0] IDX_PROG_STATUS_WORD    = 8'hd0;
   localparam logic [7:0] IDX_ARITH_MAIN_REG      = 8'he0;
   localparam logic [7:0] IDX_AUX_OPERAND         = 8'hf0;

   // ***************************************************************
   // reset values and implemented-bit masks
   // ***************************************************************
   localparam logic [7:0] RST_STACK_POINTER = 8'h07;
   localparam logic [7:0] RST_PORT_LATCH    = 8'hff;
   localparam logic [7:0] RST_ZERO          = 8'h00;
   localparam logic [7:0] MASK_FULL         = 8'hff;
   localparam logic [7:0] MASK_POWER_CTRL   = 8'h8f;
   localparam logic [7:0] MASK_IRQ_MASK     = 8'h9f;
   localparam logic [7:0] MASK_IRQ_PRIO     = 8'h1f;

   // slot order of the tables below
   localparam logic [4:0] SLOT_PORT_ONE   = 5'h0a;
   localparam logic [4:0] SLOT_PORT_THREE = 5'h0e;

   localparam logic [7:0] IDX_TABLE [REG_COUNT] = '{
      IDX_STACK_POINTER, IDX_DATA_POINTER_LOW, IDX_DATA_POINTER_HIGH, IDX_POWER_CONTROL,
      IDX_TIMER_CONTROL, IDX_TIMER_MODE_CFG, IDX_TIMER0_COUNT_LOW, IDX_TIMER1_COUNT_LOW,
      IDX_TIMER0_COUNT_HIGH, IDX_TIMER1_COUNT_HIGH, IDX_PORT_ONE_LATCH, IDX_SERIAL_CONTROL,
      IDX_SERIAL_DATA_HOLDING, IDX_IRQ_MASK_REG, IDX_PORT_THREE_LATCH, IDX_IRQ_PRIORITY,
      IDX_PROG_STATUS_WORD, IDX_ARITH_MAIN_REG, IDX_AUX_OPERAND};
   localparam logic [7:0] RST_TABLE [REG_COUNT] = '{
      RST_STACK_POINTER, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
      RST_ZERO, RST_ZERO, RST_ZERO, RST_PORT_LATCH, RST_ZERO, RST_ZERO, RST_ZERO,
      RST_PORT_LATCH, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
   localparam logic [7:0] MASK_TABLE [REG_COUNT] = '{
      MASK_FULL, MASK_FULL, MASK_FULL, MASK_POWER_CTRL, MASK_FULL, MASK_FULL, MASK_FULL,
      MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_IRQ_MASK,
      MASK_FULL, MASK_IRQ_PRIO, MASK_FULL, MASK_FULL, MASK_FULL};

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int MACHINE_CYCLE_OSC = 12;  // oscillator periods per machine cycle
   localparam int RST_HOLD_MC       = 2;   // machine cycles the reset pin must stay high
   localparam int PHASES_PER_MC     = MACHINE_CYCLE_OSC / 2;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [1:0] {
      RQ_IDLE,
      RQ_COUNT,
      RQ_HELD
   } rst_qual_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic                          sync_first;
      logic                          sync_second;
      rst_qual_state_t               qual;
      logic [7:0]                    hold_cnt;
      logic                          phase;
      logic [2:0]                    phase_cnt;
      logic                          mc_pulse;
      logic [REG_COUNT-1:0][7:0]     regs;
      logic [31:0]                   prdata;
      logic [5:0]                    alt;
   } sfr_state_t;

endpackage

//--- sfr_space_ports_reset.sv
// Purpose: function register area, two pin ports and reset qualification
// Assumes: clock_in is the oscillator, pins and reset pin are synchronous inputs
// Notes:   software reaches the registers over apb, zero wait states

`timescale 1ns/100ps

module sfr_space_ports_reset #(
   parameter int HOLD_MC  = sfr_pkg::RST_HOLD_MC,       // machine cycles of reset pin hold
   parameter int MC_OSC   = sfr_pkg::MACHINE_CYCLE_OSC  // oscillator periods per machine cycle
) (
   input  wire logic              clock_in,             // oscillator clock
   input  wire logic              rst_in,               // synchronous reset, active high
   input  wire sfr_pkg::apb_req_t apb_in,               // apb request group
   output logic                   pready_out,           // apb ready
   output logic [31:0]            prdata_out,           // apb read data
   output logic                   pslverr_out,          // apb error, always low
   input  wire logic              ext_reset_in,         // device reset pin level
   input  wire logic [7:0]        p1_pin_in,            // port one pin levels
   output logic [7:0]             p1_pin_out,           // port one driven value
   output logic [7:0]             p1_pin_oe_out,        // port one drive enable
   output logic [7:0]             p1_pullup_out,        // port one pull-up present
   input  wire logic [7:0]        p3_pin_in,            // port three pin levels
   output logic [7:0]             p3_pin_out,           // port three driven value
   output logic [7:0]             p3_pin_oe_out,        // port three drive enable
   output logic [7:0]             p3_pullup_out,        // port three pull-up present
   input  wire logic              cmp_result_in,        // comparator output
   output logic                   cmp_pos_in_out,       // comparator positive input
   output logic                   cmp_neg_in_out,       // comparator negative input
   input  wire logic              serial_tx_in,         // serial transmit data
   output logic                   serial_rx_out,        // serial receive data
   output logic                   ext_irq_zero_out,     // external interrupt zero level
   output logic                   ext_irq_one_out,      // external interrupt one level
   output logic                   count_in_zero_out,    // timer zero counter input
   output logic                   count_in_one_out,     // timer one counter input
   output logic                   int_reset_out,        // qualified internal reset
   output logic                   half_clock_out,       // divided-by-two internal clock
   output logic                   machine_cycle_out,    // one pulse per machine cycle
   output logic [7:0]             stack_pointer_out,    // stack pointer for the core
   output logic [7:0]             power_control_out     // power control bits for the core
);

   // ***************************************************************
   // constants
   // ***************************************************************
   localparam int         HOLD_CYC  = MC_OSC * HOLD_MC;
   localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYC - 1);
   localparam logic [2:0] PHASE_LAST = 3'((MC_OSC / 2) - 1);
   localparam logic [7:0] PULLUP_P1 = 8'hfc;
   localparam logic [7:0] PULLUP_P3 = 8'hbf;
   localparam logic [7:0] PIN_NONE  = 8'h40;

   sfr_pkg::sfr_state_t cur_ff;
   sfr_pkg::sfr_state_t nxt_ff;

   // ***************************************************************
   // functions
   // ***************************************************************

   // maps a register index to its table slot, msb marks a hit
   function automatic logic [5:0] find_slot(input logic [7:0] idx);
      logic [5:0] res;
      res = 6'h00;
      for (int i = 0; i < sfr_pkg::REG_COUNT; i++) begin
         if (sfr_pkg::IDX_TABLE[i] == idx) begin
            res = {1'b1, 5'(i)};
         end
      end
      return res;
   endfunction

   // register contents after any reset
   function automatic logic [sfr_pkg::REG_COUNT-1:0][7:0] reset_regs();
      logic [sfr_pkg::REG_COUNT-1:0][7:0] r;
      r = '0;
      for (int i = 0; i < sfr_pkg::REG_COUNT; i++) begin
         r[i] = sfr_pkg::RST_TABLE[i];
      end
      return r;
   endfunction

   // ***************************************************************
   // next state
   // ***************************************************************

   // apb decode terms
   logic       setup_phase;
   logic       access_phase;
   logic [5:0] hit_slot;
   logic       addr_high_zero;

   assign setup_phase    = apb_in.psel & ~apb_in.penable;
   assign access_phase   = apb_in.psel & apb_in.penable;
   assign addr_high_zero = (apb_in.paddr[11:10] == 2'h0) & (apb_in.paddr[1:0] == 2'h0);
   assign hit_slot       = addr_high_zero ? find_slot(apb_in.paddr[9:2]) : 6'h00;

   // one process computes the whole next state
   always_comb begin
      logic [7:0] rd_val;
      logic [7:0] p3_view;
      rd_val  = 8'h00;
      p3_view = 8'h00;
      nxt_ff  = cur_ff;

      // two-flop synchroniser on the reset pin
      nxt_ff.sync_first  = ext_reset_in;
      nxt_ff.sync_second = cur_ff.sync_first;

      // divide by two, then six phases make one machine cycle
      nxt_ff.phase    = ~cur_ff.phase;
      nxt_ff.mc_pulse = 1'b0;
      if (cur_ff.phase) begin
         if (cur_ff.phase_cnt == PHASE_LAST) begin
            nxt_ff.phase_cnt = 3'h0;
            nxt_ff.mc_pulse  = 1'b1;
         end else begin
            nxt_ff.phase_cnt = cur_ff.phase_cnt + 3'h1;
         end
      end

      // reset qualifier: short glitches on the pin never reach the registers
      case (cur_ff.qual)
         sfr_pkg::RQ_IDLE: begin
            nxt_ff.hold_cnt = 8'h00;
            if (cur_ff.sync_second) begin
               nxt_ff.qual     = sfr_pkg::RQ_COUNT;
               nxt_ff.hold_cnt = 8'h01;
            end
         end
         sfr_pkg::RQ_COUNT: begin
            if (!cur_ff.sync_second) begin
               nxt_ff.qual     = sfr_pkg::RQ_IDLE;
               nxt_ff.hold_cnt = 8'h00;
            end else if (cur_ff.hold_cnt == HOLD_LAST) begin
               nxt_ff.qual     = sfr_pkg::RQ_HELD;
            end else begin
               nxt_ff.hold_cnt = cur_ff.hold_cnt + 8'h01;
            end
         end
         sfr_pkg::RQ_HELD: begin
            if (!cur_ff.sync_second) begin
               nxt_ff.qual     = sfr_pkg::RQ_IDLE;
               nxt_ff.hold_cnt = 8'h00;
            end
         end
         default: begin
            nxt_ff.qual     = sfr_pkg::RQ_IDLE;
            nxt_ff.hold_cnt = 8'h00;
         end
      endcase

      // sample alternate-function inputs from port three pins
      nxt_ff.alt = p3_pin_in[5:0];

      // read data is captured in the setup cycle so it leaves a flop
      p3_view = {p3_pin_in[7], cmp_result_in, p3_pin_in[5:0]};
      if (setup_phase && !apb_in.pwrite) begin
         if (!hit_slot[5]) begin
            rd_val = 8'h00;
         end else if (hit_slot[4:0] == sfr_pkg::SLOT_PORT_ONE) begin
            rd_val = p1_pin_in;
         end else if (hit_slot[4:0] == sfr_pkg::SLOT_PORT_THREE) begin
            rd_val = p3_view;
         end else begin
            rd_val = cur_ff.regs[hit_slot[4:0]] & sfr_pkg::MASK_TABLE[hit_slot[4:0]];
         end
         nxt_ff.prdata = {24'h000000, rd_val};
      end

      // writes land at the access edge; unmapped writes are dropped
      if (access_phase && apb_in.pwrite && hit_slot[5]) begin
         nxt_ff.regs[hit_slot[4:0]] = apb_in.pwdata[7:0] & sfr_pkg::MASK_TABLE[hit_slot[4:0]];
      end

      // a qualified pin reset overrides any write in flight
      if (nxt_ff.qual == sfr_pkg::RQ_HELD) begin
         nxt_ff.regs      = reset_regs();
         nxt_ff.phase_cnt = 3'h0;
      end

      // bus reset zeroes the state, then loads the register reset values and sets alt to all ones
      if (rst_in) begin
         nxt_ff             = '0;
         nxt_ff.qual        = sfr_pkg::RQ_IDLE;
         nxt_ff.regs        = reset_regs();
         nxt_ff.alt         = 6'h3f;
      end
   end

   // ***************************************************************
   // state register
   // ***************************************************************

   // single register for the whole state
   always_ff @(posedge clock_in) begin
      cur_ff <= nxt_ff;
   end

   // ***************************************************************
   // pins
   // ***************************************************************

   // pins only ever drive low; a one is left to the pull-up, or to the board on port one bits 0, 1, so the pin can be read
   logic [7:0] p1_latch;
   logic [7:0] p3_latch;
   logic [7:0] p3_drive;

   assign p1_latch = cur_ff.regs[sfr_pkg::SLOT_PORT_ONE];
   assign p3_latch = cur_ff.regs[sfr_pkg::SLOT_PORT_THREE];

   // serial transmit shares bit one; either source can pull the pin low
   assign p3_drive = {p3_latch[7:2], p3_latch[1] & serial_tx_in, p3_latch[0]};

   // reset pin gates the drivers directly, with no clock edge in between
   assign p1_pin_out    = 8'h00;
   assign p1_pin_oe_out = ~p1_latch & {8{~ext_reset_in}};
   assign p3_pin_out    = 8'h00;
   assign p3_pin_oe_out = ~p3_drive & ~PIN_NONE & {8{~ext_reset_in}};
   assign p1_pullup_out = PULLUP_P1;
   assign p3_pullup_out = PULLUP_P3;

   // comparator inputs come straight from the analog pins
   assign cmp_pos_in_out = p1_pin_in[0];
   assign cmp_neg_in_out = p1_pin_in[1];

   // ***************************************************************
   // other outputs
   // ***************************************************************

   // alternate functions come from the sampling flops
   assign serial_rx_out     = cur_ff.alt[0];
   assign ext_irq_zero_out  = cur_ff.alt[2];
   assign ext_irq_one_out   = cur_ff.alt[3];
   assign count_in_zero_out = cur_ff.alt[4];
   assign count_in_one_out  = cur_ff.alt[5];

   // apb answers in the first access cycle
   assign pready_out  = access_phase;
   assign prdata_out  = cur_ff.prdata;
   assign pslverr_out = 1'b0;

   // timing and core-facing outputs
   assign int_reset_out     = (cur_ff.qual == sfr_pkg::RQ_HELD);
   assign half_clock_out    = cur_ff.phase;
   assign machine_cycle_out = cur_ff.mc_pulse;
   assign stack_pointer_out = cur_ff.regs[0];
   assign power_control_out = cur_ff.regs[3] & sfr_pkg::MASK_POWER_CTRL;

endmodule

//--- sfr_chk_properties.sv
// Purpose: concurrent checks on pins, reset pin qualification and timing outputs
// Assumes: bound to every instance of the block, counts come from its parameters
// Notes:   pin-hold count is kept in a small saturating helper counter
`timescale 1ns/100ps
module sfr_chk #(
   parameter int HOLD_MC = 2,                // machine cycles of pin hold
   parameter int MC_OSC  = 12                // clocks per machine cycle
) (
   input wire logic       clock_in,          // clock
   input wire logic       rst_in,            // sync reset
   input wire logic       ext_reset_in,      // reset pin
   input wire logic [7:0] p1_pin_in,         // port one pins
   input wire logic [7:0] p3_pin_in,         // port three pins
   input wire logic [7:0] p1_pin_oe_out,     // port one drive
   input wire logic [7:0] p3_pin_oe_out,     // port three drive
   input wire logic [7:0] p1_pullup_out,     // port one pull-ups
   input wire logic [7:0] p3_pullup_out,     // port three pull-ups
   input wire logic       cmp_pos_in_out,    // comparator plus
   input wire logic       cmp_neg_in_out,    // comparator minus
   input wire logic       serial_rx_out,     // serial receive
   input wire logic       ext_irq_zero_out,  // irq zero
   input wire logic       ext_irq_one_out,   // irq one
   input wire logic       count_in_zero_out, // counter zero
   input wire logic       count_in_one_out,  // counter one
   input wire logic       int_reset_out,     // qualified reset
   input wire logic       half_clock_out,    // half clock
   input wire logic       machine_cycle_out, // machine cycle pulse
   input wire logic [7:0] stack_pointer_out  // stack pointer
);
   // ****************************************************************
   // checks
   // ****************************************************************
   localparam int LIM = HOLD_MC * MC_OSC;
   logic [7:0] hi_ff;
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   // consecutive high samples of the pin, saturating so long holds never wrap
   always_ff @(posedge clock_in) hi_ff <= ext_reset_in ? hi_ff + {7'h00, hi_ff != 8'hff} : 8'h00;
   property p_pull; p1_pullup_out == 8'hfc && p3_pullup_out == 8'hbf; endproperty
   a_pull: assert property (p_pull) else $error("pull-up map wrong");
   property p_cmp; cmp_pos_in_out == p1_pin_in[0] && cmp_neg_in_out == p1_pin_in[1]; endproperty
   a_cmp: assert property (p_cmp) else $error("comparator inputs wrong");
   property p_rel; ext_reset_in |-> p1_pin_oe_out == 8'h00 && p3_pin_oe_out == 8'h00; endproperty
   a_rel: assert property (p_rel) else $error("pins not released on reset pin");
   property p_half; !$past(rst_in) |-> half_clock_out != $past(half_clock_out); endproperty
   a_half: assert property (p_half) else $error("half clock did not toggle");
   property p_mc_gap; machine_cycle_out |=> !machine_cycle_out [*8]; endproperty
   a_mc_gap: assert property (p_mc_gap) else $error("machine pulse too soon");
   // a qualified pin reset restarts the machine-cycle phase, so a period open at that moment is dropped
   property p_mc_per; disable iff (rst_in || int_reset_out) machine_cycle_out |-> ##12 machine_cycle_out; endproperty
   a_mc_per: assert property (p_mc_per) else $error("machine pulse period wrong");
   property p_qmin; $rose(int_reset_out) |-> hi_ff >= LIM; endproperty
   a_qmin: assert property (p_qmin) else $error("internal reset too early");
   property p_qmax; hi_ff == LIM + 4 |-> int_reset_out; endproperty
   a_qmax: assert property (p_qmax) else $error("internal reset missing");
   property p_qdrop; $fell(ext_reset_in) |-> ##[1:4] !int_reset_out; endproperty
   a_qdrop: assert property (p_qdrop) else $error("internal reset stuck");
   property p_sp; int_reset_out && $past(int_reset_out) |-> stack_pointer_out == 8'h07; endproperty
   a_sp: assert property (p_sp) else $error("stack not reset");
   property p_alt; !$past(rst_in) |-> {count_in_one_out, count_in_zero_out, ext_irq_one_out, ext_irq_zero_out,
      serial_rx_out} == {$past(p3_pin_in[5:2]), $past(p3_pin_in[0])}; endproperty
   a_alt: assert property (p_alt) else $error("alternate inputs wrong");
endmodule
bind sfr_space_ports_reset sfr_chk #(.HOLD_MC(HOLD_MC), .MC_OSC(MC_OSC)) chk (.clock_in, .rst_in, .ext_reset_in,
   .p1_pin_in, .p3_pin_in, .p1_pin_oe_out, .p3_pin_oe_out, .p1_pullup_out, .p3_pullup_out, .cmp_pos_in_out,
   .cmp_neg_in_out, .serial_rx_out, .ext_irq_zero_out, .ext_irq_one_out, .count_in_zero_out, .count_in_one_out,
   .int_reset_out, .half_clock_out, .machine_cycle_out, .stack_pointer_out);

//--- pin_world.sv
// Purpose: board around the ports, resolving each pin and making the comparator
// Assumes: device only sinks, external drivers may push either level
// Notes:   a line nobody holds shows the inverse of its last level
`timescale 1ns/100ps
module pin_world (
   input  wire logic        clock_in,    // clock
   input  wire logic [7:0]  p1_oe_in,    // device sinks port one
   input  wire logic [7:0]  p1_pu_in,    // device pull-ups port one
   input  wire logic [7:0]  p3_oe_in,    // device sinks port three
   input  wire logic [7:0]  p3_pu_in,    // device pull-ups port three
   input  wire logic [15:0] drv_en_in,   // external drivers, port three high
   input  wire logic [15:0] drv_val_in,  // external levels
   input  wire logic        ext_pull_in, // board pull-ups on port one bits 0, 1
   output logic [7:0]       p1_out,      // port one level
   output logic [7:0]       p3_out,      // port three level
   output logic             cmp_out      // comparator result
);
   // ****************************************************************
   // pin resolution
   // ****************************************************************
   logic [15:0] last_ff = 16'h0000;
   function automatic logic [7:0] res(input logic [7:0] oe, pu, en, val, last);
      return ~oe & ((en & val) | (~en & pu) | (~en & ~pu & ~last));
   endfunction
   // remembered level so floating lines never look stable
   always_ff @(posedge clock_in) last_ff <= {p3_out, p1_out};
   assign p1_out  = res(p1_oe_in, p1_pu_in | {6'h00, {2{ext_pull_in}}}, drv_en_in[7:0], drv_val_in[7:0], last_ff[7:0]);
   assign p3_out  = res(p3_oe_in, p3_pu_in, drv_en_in[15:8], drv_val_in[15:8], last_ff[15:8]);
   assign cmp_out = p1_out[0] & ~p1_out[1];
endmodule

//--- sfr_space_ports_reset_tb.sv
// Purpose: self-checking bench for register area, ports and reset pin
// Assumes: default pin hold of two machine cycles, board pull-ups fitted on port one bits 0, 1
// Notes:   random writes and reads mixed with pin and reset corners
`timescale 1ns/100ps
module sfr_space_ports_reset_tb;
   // ****************************************************************
   // bench
   // ****************************************************************
   localparam int LIM = sfr_pkg::RST_HOLD_MC * sfr_pkg::MACHINE_CYCLE_OSC;  // clocks of a qualifying pin hold
   logic clock_in, rst_in, ext_reset_in, ext_pull, tx, cmp, pready, pslverr, irst, half, mcy;
   logic [7:0] p1_oe, p3_oe, p1_pu, p3_pu, p1_pin, p3_pin, power_control, p1_drv, p3_drv;
   logic [15:0] drv_en, drv_val;
   logic [31:0] prdata, rd;
   logic [7:0] mdl [sfr_pkg::REG_COUNT];
   sfr_pkg::apb_req_t req;
   int fails, checks, n, s;
   sfr_space_ports_reset #(.HOLD_MC(sfr_pkg::RST_HOLD_MC), .MC_OSC(sfr_pkg::MACHINE_CYCLE_OSC)) DUT (.clock_in,
      .rst_in, .apb_in(req), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .ext_reset_in,
      .p1_pin_in(p1_pin), .p1_pin_out(p1_drv), .p1_pin_oe_out(p1_oe), .p1_pullup_out(p1_pu), .p3_pin_in(p3_pin),
      .p3_pin_out(p3_drv), .p3_pin_oe_out(p3_oe),
      .p3_pullup_out(p3_pu), .cmp_result_in(cmp), .cmp_pos_in_out(), .cmp_neg_in_out(), .serial_tx_in(tx),
      .serial_rx_out(), .ext_irq_zero_out(), .ext_irq_one_out(), .count_in_zero_out(), .count_in_one_out(),
      .int_reset_out(irst), .half_clock_out(half), .machine_cycle_out(mcy), .stack_pointer_out(),
      .power_control_out(power_control));
   pin_world world (.clock_in, .p1_oe_in(p1_oe), .p1_pu_in(p1_pu), .p3_oe_in(p3_oe), .p3_pu_in(p3_pu),
      .drv_en_in(drv_en), .drv_val_in(drv_val), .ext_pull_in(ext_pull), .p1_out(p1_pin), .p3_out(p3_pin),
      .cmp_out(cmp));
   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end
   // port reads give pin levels; bit six of port three gives the comparator
   function automatic logic [7:0] exp_rd(input int k);
      logic [7:0] a, b;
      a = mdl[sfr_pkg::SLOT_PORT_ONE] & (~drv_en[7:0] | drv_val[7:0]);
      b = mdl[sfr_pkg::SLOT_PORT_THREE] & (~drv_en[15:8] | drv_val[15:8]) & {6'h3f, tx, 1'b1};
      b[6] = a[0] & ~a[1];
      return k == 10 ? a : (k == 14 ? b : mdl[k]);
   endfunction
   task automatic chk_rd(input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_sig(input logic [7:0] e, g);
      chk_rd({24'h000000, e}, {24'h000000, g});
   endtask
   // one apb transfer, request held until ready is seen high
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int k;
      @(posedge clock_in);
      req <= '{1'b1, 1'b0, w, {2'b00, idx, 2'b00}, {24'h000000, d}};
      @(posedge clock_in);
      req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock_in);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      req <= '0;
      if (k >= 20) fails++;
   endtask
   task automatic rdchk(input int k);
      xfer(1'b0, sfr_pkg::IDX_TABLE[k], 8'h00);
      chk_rd({24'h000000, exp_rd(k)}, rd);
   endtask
   task automatic end_of_test;
      if (fails == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (10000) @(posedge clock_in);
      fails++;
      end_of_test;
   end
   initial begin
      {rst_in, ext_reset_in, ext_pull, tx, req, drv_en, drv_val} = {4'hb, 79'h0};
      fails = 0;
      checks = 0;
      foreach (mdl[i]) mdl[i] = sfr_pkg::RST_TABLE[i];
      void'($urandom(9));
      repeat (4) @(posedge clock_in);
      rst_in <= 1'b0;
      for (s = 0; s < 19; s++) rdchk(s);
      chk_sig(8'hfc, p1_pu);
      chk_sig(8'hbf, p3_pu);
      xfer(1'b1, 8'h80, 8'h00);
      xfer(1'b0, 8'h80, 8'h00);
      chk_rd(32'h00000000, rd);
      chk_sig(8'h00, {7'h00, pslverr});
      // random traffic with shifting external drive, port three bit six left alone
      repeat (60) begin
         s = $urandom_range(18);
         n = $urandom_range(255);
         @(posedge clock_in);
         drv_en <= 16'($urandom) & 16'hbfff;
         drv_val <= 16'($urandom);
         tx <= ($urandom_range(3) != 0);
         xfer(1'b1, sfr_pkg::IDX_TABLE[s], n[7:0]);
         mdl[s] = n[7:0] & sfr_pkg::MASK_TABLE[s];
         rdchk($urandom_range(18));
         chk_sig(~mdl[10], p1_oe);
         chk_sig(~(mdl[14] & {6'h3f, tx, 1'b1}) & 8'hbf, p3_oe);
         chk_sig(mdl[3], power_control);
         chk_sig(8'h00, p1_drv | p3_drv);
      end
      // short pin pulse only releases the pins
      xfer(1'b1, sfr_pkg::IDX_PORT_ONE_LATCH, 8'h00);
      mdl[10] = 8'h00;
      ext_reset_in <= 1'b1;
      #1 chk_sig(8'h00, p1_oe | p3_oe);
      repeat (LIM - 2) @(posedge clock_in);
      chk_sig(8'h00, {7'h00, irst});
      ext_reset_in <= 1'b0;
      rdchk(10);
      // long hold gives the full reset, a write meanwhile is lost
      @(posedge clock_in);
      ext_reset_in <= 1'b1;
      repeat (LIM + 6) @(posedge clock_in);
      chk_sig(8'h01, {7'h00, irst});
      xfer(1'b1, sfr_pkg::IDX_ARITH_MAIN_REG, 8'h5a);
      ext_reset_in <= 1'b0;
      foreach (mdl[i]) mdl[i] = sfr_pkg::RST_TABLE[i];
      repeat (4) @(posedge clock_in);
      for (s = 0; s < 19; s++) rdchk(s);
      {n, s} = 64'h0;
      repeat (120) begin
         @(posedge clock_in);
         #1 n += (mcy === 1'b1);
         s += (half === 1'b1);
      end
      chk_rd(32'd10, n);
      chk_rd(32'd60, s);
      end_of_test;
   end
endmodule
